// ===== src/bst_regs.svh
`ifndef BST_REGS_SVH
`define BST_REGS_SVH

// instruction register
`define BST_IR_LEN 3
`define BST_IR_EXTEST 3'h0
`define BST_IR_IDCODE 3'h1
`define BST_IR_SAMPLE_Z 3'h2
`define BST_IR_SAMPLE 3'h4
`define BST_IR_BYPASS 3'h7
`define BST_IR_CAPTURE 3'h1

// identification register
`define BST_ID_LEN 32

// boundary scan register layout: inputs low, outputs above, control cell on top
`define BST_NIN 4
`define BST_NOUT 4
`define BST_OUT_LSB 4
`define BST_CTL_BIT 8
`define BST_LEN 9
`define BST_PRE_RST 9'h100

// tms high count that forces the reset state
`define BST_RESET_TMS 3'h5

`endif

// ===== src/bst_pkg.sv
package bst_pkg;

   typedef enum logic [3:0] {
      st_reset, st_idle,
      st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr, st_pause_dr, st_exit2_dr, st_upd_dr,
      st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir, st_pause_ir, st_exit2_ir, st_upd_ir
   } tap_state_type;

   typedef enum logic [1:0] {
      dr_bypass, dr_id, dr_bsr
   } dr_sel_type;

endpackage : bst_pkg

// ===== src/bst_bsr.sv
`timescale 1ns/1ps
`include "bst_regs.svh"

module bst_bsr (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // controls, one-cycle pulses except preset, which is a level held through the reset state
   input wire logic capture,
   input wire logic shift,
   input wire logic update,
   input wire logic preset,
   // serial path
   input wire logic sin,
   output logic sout,
   // parallel side
   input wire logic [`BST_LEN-1:0] cap_vec,
   output logic [`BST_LEN-1:0] preload
);
   import bst_pkg::*;

   logic [`BST_LEN-1:0] shift_reg;
   logic [`BST_LEN-1:0] shift_next;
   logic [`BST_LEN-1:0] preload_reg;
   logic [`BST_LEN-1:0] preload_next;
   logic [`BST_LEN:0] chain;

   ////////////////////////////////////////////////////////////////////////////
   // serial input enters the top cell and moves towards bit zero
   assign chain = {sin, shift_reg};

   genvar i;
   generate
      for (i = 0; i < `BST_LEN; i = i + 1) begin : g_cell
         assign shift_next[i] = capture ? cap_vec[i] : (shift ? chain[i+1] : shift_reg[i]);
      end
   endgenerate

   always_comb begin
      preload_next = preload_reg;
      if (preset) begin
         preload_next = `BST_PRE_RST;
      end else if (update) begin
         preload_next = shift_reg;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         shift_reg <= '0;
         preload_reg <= `BST_PRE_RST;
      end else if (clk_en) begin
         shift_reg <= shift_next;
         preload_reg <= preload_next;
      end
   end

   assign sout = shift_reg[0];
   assign preload = preload_reg;

   ////////////////////////////////////////////////////////////////////////////
   chk_bsr_shift: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && shift && !capture) |=> shift_reg == {$past(sin), $past(shift_reg[`BST_LEN-1:1])})
      else $error("boundary register did not shift one place");

   chk_bsr_capture: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && capture) |=> shift_reg == $past(cap_vec))
      else $error("boundary register missed the ring capture");

endmodule : bst_bsr

// ===== src/bst_tap.sv
`timescale 1ns/1ps
`include "bst_regs.svh"

// Notes on behaviour
// - sample inputs on tck rise, launch on fall
// - tms steers controller, pulled high when open
// - tdi enters selected register msb, pulled high
// - tdo from lsb, falls only, shift states
// - one register in path, chosen by instruction
// - five tms-high rises reset the port
// - power-up reset leaves tdo high impedance
// - three-bit instruction, idcode after any reset
// - capture-ir loads 01 into low bits
// - bypass bit, cleared when bypass takes effect
// - boundary register captures ring, shifts in shift-dr
// - extest, sample, sample-z capture the ring
// - idle port leaves memory operation untouched
// - idcode selects fixed 32-bit code capture
// - new instruction acts only after update-ir
// - sample-z floats output bus until replaced
// - extest drives preload onto output pins
module bst_tap #(
   parameter logic [`BST_ID_LEN-1:0] ID_CODE = 32'h0a5a_5001 // arbitrary value, bit zero set
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   // test port pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   // io ring
   input wire logic [`BST_NIN-1:0] pin_in,
   input wire logic [`BST_NOUT-1:0] core_out,
   input wire logic core_out_oe,
   output logic [`BST_NOUT-1:0] pin_out,
   output logic pin_out_oe,
   // observation
   output bst_pkg::tap_state_type tap_state
);
   import bst_pkg::*;

   localparam int SW = `BST_NIN + 3;

   logic [SW-1:0] sync1_reg;
   logic [SW-1:0] sync2_reg;
   logic tck_d_reg;
   logic tck_s;
   logic tms_s;
   logic tdi_s;
   logic [`BST_NIN-1:0] pin_in_s;
   logic tck_rise;
   logic tck_fall;

   tap_state_type state_reg;
   tap_state_type state_next;
   logic [2:0] ones_reg;
   logic [2:0] ones_next;

   logic [`BST_IR_LEN-1:0] ir_shift_reg;
   logic [`BST_IR_LEN-1:0] ir_shift_next;
   logic [`BST_IR_LEN-1:0] ir_reg;
   logic [`BST_IR_LEN-1:0] ir_next;
   logic bypass_reg;
   logic bypass_next;
   logic [`BST_ID_LEN-1:0] id_reg;
   logic [`BST_ID_LEN-1:0] id_next;
   logic tdo_reg;
   logic tdo_next;
   logic tdo_oe_reg;
   logic tdo_oe_next;

   dr_sel_type dr_sel;
   logic dr_lsb;
   logic bsr_capture;
   logic bsr_shift;
   logic bsr_update;
   logic bsr_sout;
   logic [`BST_LEN-1:0] bsr_cap;
   logic [`BST_LEN-1:0] preload;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers; the pull-ups on tms and tdi live in the pad ring
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         tck_d_reg <= 1'b0;
      end else if (clk_en) begin
         sync1_reg <= {tck, tms, tdi, pin_in};
         sync2_reg <= sync1_reg;
         tck_d_reg <= tck_s;
      end
   end

   assign tck_s = sync2_reg[SW-1];
   assign tms_s = sync2_reg[SW-2];
   assign tdi_s = sync2_reg[SW-3];
   assign pin_in_s = sync2_reg[`BST_NIN-1:0];
   assign tck_rise = tck_s & ~tck_d_reg;
   assign tck_fall = ~tck_s & tck_d_reg;

   ////////////////////////////////////////////////////////////////////////////
   // controller
   always_comb begin
      state_next = state_reg;
      if (tck_rise) begin
         unique case (state_reg)
            st_reset: state_next = tms_s ? st_reset : st_idle;
            st_idle: state_next = tms_s ? st_sel_dr : st_idle;
            st_sel_dr: state_next = tms_s ? st_sel_ir : st_cap_dr;
            st_cap_dr: state_next = tms_s ? st_exit1_dr : st_shift_dr;
            st_shift_dr: state_next = tms_s ? st_exit1_dr : st_shift_dr;
            st_exit1_dr: state_next = tms_s ? st_upd_dr : st_pause_dr;
            st_pause_dr: state_next = tms_s ? st_exit2_dr : st_pause_dr;
            st_exit2_dr: state_next = tms_s ? st_upd_dr : st_shift_dr;
            st_upd_dr: state_next = tms_s ? st_sel_dr : st_idle;
            st_sel_ir: state_next = tms_s ? st_reset : st_cap_ir;
            st_cap_ir: state_next = tms_s ? st_exit1_ir : st_shift_ir;
            st_shift_ir: state_next = tms_s ? st_exit1_ir : st_shift_ir;
            st_exit1_ir: state_next = tms_s ? st_upd_ir : st_pause_ir;
            st_pause_ir: state_next = tms_s ? st_exit2_ir : st_pause_ir;
            st_exit2_ir: state_next = tms_s ? st_upd_ir : st_shift_ir;
            st_upd_ir: state_next = tms_s ? st_sel_dr : st_idle;
         endcase
      end
   end

   // counts tms-high rises for checking the five-edge reset
   always_comb begin
      ones_next = ones_reg;
      if (tck_rise) begin
         if (!tms_s) begin
            ones_next = 3'h0;
         end else if (ones_reg != `BST_RESET_TMS) begin
            ones_next = ones_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= st_reset;
         ones_reg <= 3'h0;
      end else if (clk_en) begin
         state_reg <= state_next;
         ones_reg <= ones_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data register selection; reserved codes fall back to bypass
   always_comb begin
      unique case (ir_reg)
         `BST_IR_EXTEST, `BST_IR_SAMPLE, `BST_IR_SAMPLE_Z: dr_sel = dr_bsr;
         `BST_IR_IDCODE: dr_sel = dr_id;
         default: dr_sel = dr_bypass;
      endcase
   end

   always_comb begin
      dr_lsb = bypass_reg;
      unique case (dr_sel)
         dr_bypass: dr_lsb = bypass_reg;
         dr_id: dr_lsb = id_reg[0];
         dr_bsr: dr_lsb = bsr_sout;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // instruction, bypass, identification and tdo
   always_comb begin
      ir_shift_next = ir_shift_reg;
      ir_next = ir_reg;
      bypass_next = bypass_reg;
      id_next = id_reg;
      tdo_next = tdo_reg;
      tdo_oe_next = tdo_oe_reg;
      if (tck_rise) begin
         if (state_reg == st_cap_ir) begin
            ir_shift_next = `BST_IR_CAPTURE;
         end
         if (state_reg == st_shift_ir) begin
            ir_shift_next = {tdi_s, ir_shift_reg[`BST_IR_LEN-1:1]};
         end
         if (state_reg == st_cap_dr && dr_sel == dr_bypass) begin
            bypass_next = 1'b0;
         end
         if (state_reg == st_shift_dr && dr_sel == dr_bypass) begin
            bypass_next = tdi_s;
         end
         if (state_reg == st_cap_dr && dr_sel == dr_id) begin
            id_next = ID_CODE;
         end
         if (state_reg == st_shift_dr && dr_sel == dr_id) begin
            id_next = {tdi_s, id_reg[`BST_ID_LEN-1:1]};
         end
      end
      if (tck_fall) begin
         if (state_reg == st_upd_ir) begin
            ir_next = ir_shift_reg;
            if (ir_shift_reg == `BST_IR_BYPASS) begin
               bypass_next = 1'b0;
            end
         end
         tdo_oe_next = (state_reg == st_shift_dr) || (state_reg == st_shift_ir);
         if (tdo_oe_next) begin
            tdo_next = (state_reg == st_shift_ir) ? ir_shift_reg[0] : dr_lsb;
         end
      end
      if (state_next == st_reset) begin
         ir_next = `BST_IR_IDCODE;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ir_shift_reg <= `BST_IR_CAPTURE;
         ir_reg <= `BST_IR_IDCODE;
         bypass_reg <= 1'b0;
         id_reg <= '0;
         tdo_reg <= 1'b0;
         tdo_oe_reg <= 1'b0;
      end else if (clk_en) begin
         ir_shift_reg <= ir_shift_next;
         ir_reg <= ir_next;
         bypass_reg <= bypass_next;
         id_reg <= id_next;
         tdo_reg <= tdo_next;
         tdo_oe_reg <= tdo_oe_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // boundary scan register
   assign bsr_capture = tck_rise && state_reg == st_cap_dr && dr_sel == dr_bsr;
   assign bsr_shift = tck_rise && state_reg == st_shift_dr && dr_sel == dr_bsr;
   assign bsr_update = tck_fall && state_reg == st_upd_dr && dr_sel == dr_bsr;
   assign bsr_cap = {pin_out_oe, pin_out, pin_in_s};

   bst_bsr u_bsr (
      .sys_clk(sys_clk),
      .rst(rst),
      .clk_en(clk_en),
      .capture(bsr_capture),
      .shift(bsr_shift),
      .update(bsr_update),
      .preset(state_reg == st_reset),
      .sin(tdi_s),
      .sout(bsr_sout),
      .cap_vec(bsr_cap),
      .preload(preload)
   );

   // output pins follow the core unless a test instruction owns them
   always_comb begin
      pin_out = core_out;
      pin_out_oe = core_out_oe;
      if (ir_reg == `BST_IR_EXTEST) begin
         pin_out = preload[`BST_CTL_BIT-1:`BST_OUT_LSB];
         pin_out_oe = preload[`BST_CTL_BIT];
      end else if (ir_reg == `BST_IR_SAMPLE_Z) begin
         pin_out_oe = 1'b0;
      end
   end

   assign tdo = tdo_reg;
   assign tdo_oe = tdo_oe_reg;
   assign tap_state = state_reg;

   ////////////////////////////////////////////////////////////////////////////
   sequence s_cap_ir;
      clk_en && tck_rise && state_reg == st_cap_ir;
   endsequence

   sequence s_upd_ir;
      clk_en && tck_fall && state_reg == st_upd_ir;
   endsequence

   sequence s_id_cap;
      clk_en && tck_rise && state_reg == st_cap_dr && ir_reg == `BST_IR_IDCODE;
   endsequence

   chk_five_reset: assert property (@(posedge sys_clk) disable iff (rst)
      ones_reg == `BST_RESET_TMS |-> state_reg == st_reset)
      else $error("five tms-high rises did not reach reset");

   chk_reset_idcode: assert property (@(posedge sys_clk) disable iff (rst)
      state_reg == st_reset |-> ir_reg == `BST_IR_IDCODE)
      else $error("reset state without idcode instruction");

   chk_capture_ir: assert property (@(posedge sys_clk) disable iff (rst)
      s_cap_ir |=> ir_shift_reg[1:0] == 2'h1)
      else $error("capture-ir did not load 01");

   chk_ir_update: assert property (@(posedge sys_clk) disable iff (rst)
      $changed(ir_reg) |-> $past(tck_fall && state_reg == st_upd_ir) || state_reg == st_reset)
      else $error("instruction changed outside update-ir");

   chk_ir_install: assert property (@(posedge sys_clk) disable iff (rst)
      s_upd_ir ##1 state_reg != st_reset |-> ir_reg == $past(ir_shift_reg))
      else $error("update-ir did not install shifted instruction");

   chk_tdo_falling: assert property (@(posedge sys_clk) disable iff (rst)
      $changed(tdo_reg) || $changed(tdo_oe_reg) |-> $past(tck_fall))
      else $error("tdo changed away from a falling tck");

   chk_tdo_shift: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(tdo_oe_reg) |-> state_reg == st_shift_dr || state_reg == st_shift_ir)
      else $error("tdo driven outside a shift state");

   chk_bypass_clear: assert property (@(posedge sys_clk) disable iff (rst)
      (clk_en && tck_rise && state_reg == st_cap_dr && dr_sel == dr_bypass) |=> !bypass_reg)
      else $error("bypass bit not cleared on capture");

   chk_id_capture: assert property (@(posedge sys_clk) disable iff (rst)
      s_id_cap |=> id_reg == ID_CODE)
      else $error("identification code not captured");

   chk_sample_z: assert property (@(posedge sys_clk) disable iff (rst)
      ir_reg == `BST_IR_SAMPLE_Z |-> !pin_out_oe)
      else $error("output bus driven under sample-z");

   chk_extest_drive: assert property (@(posedge sys_clk) disable iff (rst)
      ir_reg == `BST_IR_EXTEST |-> pin_out == preload[`BST_CTL_BIT-1:`BST_OUT_LSB]
         && pin_out_oe == preload[`BST_CTL_BIT])
      else $error("extest pins do not follow preload");

endmodule : bst_tap

// ===== test/bst_host.sv
`timescale 1ns/1ps

module bst_host (
   // link pins
   output logic tck,
   output logic tms,
   output logic tdi,
   // serial return, z when released
   input wire logic tdo_pin
);
   // idle link: clock parked low, data lines at their pull-up level
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   ////////////////////////////////////////////////////////////
   // one link clock: lines move while low, tdo taken just before the rise
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #62;
      q = tdo_pin;
      tck = 1'b1;
      #63;
      tck = 1'b0;
   endtask : step

   task automatic reset5();
      logic q;
      repeat (5) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask : reset5

   // full scan from idle back to idle through the update state
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
      output logic [31:0] dout, output logic drv);
      logic q;
      dout = 32'h0;
      drv = 1'b1;
      step(1'b1, 1'b1, q);
      if (ir) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
         drv = drv & (q !== 1'bz);
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask : scan

endmodule : bst_host

// ===== test/testbench.sv
`timescale 1ns/1ps
`include "bst_regs.svh"

module testbench;
   import bst_pkg::*;

   typedef struct {
      logic [2:0] code;
      logic [31:0] dout;
      logic [3:0] pins;
      logic pins_oe;
   } bst_row_type;

   localparam logic [31:0] ID_VAL = 32'h1357_2469; // arbitrary value
   localparam logic [31:0] PAT = 32'hc3a5_96e1;
   localparam logic [3:0] PIN_VAL = 4'h6;
   localparam logic [3:0] CORE_VAL = 4'h9;

   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic [3:0] pin_in = PIN_VAL;
   logic [3:0] core_out = CORE_VAL;
   logic core_out_oe = 1'b1;
   logic tck, tms, tdi, tdo, tdo_oe, pin_out_oe;
   logic [3:0] pin_out;
   tap_state_type tap_state;
   wire tdo_pin = tdo_oe ? tdo : 1'bz;
   int n_fail = 0;
   int checks = 0;
   bst_row_type rows [8];

   always #5 sys_clk = ~sys_clk;

   bst_tap #(.ID_CODE(ID_VAL)) i_dut (
      .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out), .core_out_oe(core_out_oe),
      .pin_out(pin_out), .pin_out_oe(pin_out_oe), .tap_state(tap_state)
   );

   bst_host i_host (.tck(tck), .tms(tms), .tdi(tdi), .tdo_pin(tdo_pin));

   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   // link edges kept clear of system clock edges
   task automatic align();
      @(negedge sys_clk);
      #2;
   endtask : align

   initial begin
      #200_000;
      n_fail++;
      close_out();
   end

   ////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] dout;
      logic [2:0] code;
      logic drv;
      logic q;
      for (int r = 0; r < 8; r++) begin
         rows[r] = '{3'(r), {PAT[30:0], 1'b0}, CORE_VAL, 1'b1};
      end
      rows[0] = '{`BST_IR_EXTEST, {PAT[22:0], 1'b1, 4'h0, PIN_VAL}, PAT[30:27], PAT[31]};
      rows[1] = '{`BST_IR_IDCODE, ID_VAL, CORE_VAL, 1'b1};
      rows[2] = '{`BST_IR_SAMPLE_Z, {PAT[22:0], 1'b0, CORE_VAL, PIN_VAL}, CORE_VAL, 1'b0};
      rows[4] = '{`BST_IR_SAMPLE, {PAT[22:0], 1'b1, CORE_VAL, PIN_VAL}, CORE_VAL, 1'b1};
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      align();
      for (int r = 0; r < 8; r++) begin
         i_host.reset5();
         check({28'h0, tap_state}, {28'h0, st_idle}, "idle");
         i_host.scan(1'b1, 3, {29'h0, rows[r].code}, dout, drv);
         check(dout, {29'h0, `BST_IR_CAPTURE}, "ir capture");
         i_host.scan(1'b0, 32, PAT, dout, drv);
         check(dout, rows[r].dout, "dr path");
         check({31'h0, drv}, 32'h1, "tdo driven");
         check({31'h0, tdo_oe}, 32'h0, "tdo idle");
         check({28'h0, pin_out}, {28'h0, rows[r].pins}, "pins");
         check({31'h0, pin_out_oe}, {31'h0, rows[r].pins_oe}, "pins oe");
      end
      // extest with control cell off, then five tms-high rises from shift
      i_host.reset5();
      i_host.scan(1'b1, 3, {29'h0, `BST_IR_EXTEST}, dout, drv);
      i_host.scan(1'b0, 32, ~PAT, dout, drv);
      check({27'h0, pin_out_oe, pin_out}, {27'h0, ~PAT[31:27]}, "extest pins");
      i_host.step(1'b1, 1'b1, q);
      i_host.step(1'b0, 1'b1, q);
      i_host.step(1'b0, 1'b1, q);
      repeat (4) i_host.step(1'b1, 1'b1, q);
      check({28'h0, tap_state}, {28'h0, st_sel_ir}, "four highs");
      i_host.step(1'b1, 1'b1, q);
      check({28'h0, tap_state}, {28'h0, st_reset}, "five highs");
      check({27'h0, pin_out_oe, pin_out}, {27'h0, 1'b1, CORE_VAL}, "pins back");
      // frozen clock enable hides link edges
      i_host.step(1'b0, 1'b1, q);
      @(posedge sys_clk) clk_en <= 1'b0;
      align();
      i_host.step(1'b1, 1'b1, q);
      check({28'h0, tap_state}, {28'h0, st_idle}, "frozen");
      @(posedge sys_clk) clk_en <= 1'b1;
      align();
      i_host.step(1'b1, 1'b1, q);
      check({28'h0, tap_state}, {28'h0, st_sel_dr}, "running");
      // instruction parked in pause stays inactive until update
      code = `BST_IR_SAMPLE_Z;
      i_host.step(1'b1, 1'b1, q);
      i_host.step(1'b0, 1'b1, q);
      i_host.step(1'b0, 1'b1, q);
      for (int i = 0; i < 3; i++) i_host.step(i == 2, code[i], q);
      i_host.step(1'b0, 1'b1, q);
      check({28'h0, tap_state}, {28'h0, st_pause_ir}, "pause ir");
      check({31'h0, pin_out_oe}, 32'h1, "not yet");
      i_host.step(1'b1, 1'b1, q);
      i_host.step(1'b1, 1'b1, q);
      // update-ir acts on the synchronised fall, a few system clocks after the pin
      repeat (4) @(negedge sys_clk);
      check({31'h0, pin_out_oe}, 32'h0, "installed");
      // second system reset in mid-run
      @(posedge sys_clk) rst <= 1'b1;
      @(posedge sys_clk) rst <= 1'b0;
      align();
      check({28'h0, tap_state}, {28'h0, st_reset}, "rst state");
      check({31'h0, tdo_oe}, 32'h0, "rst tdo");
      check({31'h0, pin_out_oe}, 32'h1, "rst pins");
      i_host.step(1'b0, 1'b1, q);
      i_host.scan(1'b0, 32, PAT, dout, drv);
      check(dout, ID_VAL, "idcode");
      close_out();
   end

endmodule : testbench
